// ===== spe_regs.vh
// supply enable register bank: offsets, field positions, fixed defaults
// assumes a 32-bit apb slave with byte addresses four times the index
`ifndef SPE_REGS_VH
`define SPE_REGS_VH

// ==========================================================
// register indices and byte addresses
`define SPE_IDX_BANK_A 8'h0c
`define SPE_IDX_BANK_B 8'h0d
`define SPE_IDX_STATUS 8'h0f
`define SPE_ADDR_BANK_A 8'h30
`define SPE_ADDR_BANK_B 8'h34
`define SPE_ADDR_STATUS 8'h3c

// ==========================================================
// bank a fields
`define SPE_A_CHG_BIT 9
`define SPE_A_BACKUP_BIT 8
`define SPE_A_AUX_BIT 7
`define SPE_A_CMP_MSB 3
`define SPE_A_CMP_LSB 0

// ==========================================================
// bank b fields
`define SPE_B_LIMSW_BIT 15
`define SPE_B_LREG4_BIT 11
`define SPE_B_LREG3_BIT 10

// ==========================================================
// status fields: actual state of limit switch, reg 4, reg 3
`define SPE_S_LIMSW_BIT 2
`define SPE_S_LREG4_BIT 1
`define SPE_S_LREG3_BIT 0

// ==========================================================
// fixed defaults and writable masks
`define SPE_A_DEFAULT 16'h0200
`define SPE_B_DEFAULT 16'h0000
`define SPE_A_WMASK 16'h038f
`define SPE_B_WMASK 16'h8c00
`define SPE_A_KEYMASK 16'h0200

`endif

// ===== spe_supply_gate.v
// supply gate: turns enable requests into actual on state
// assumes permit inputs are synchronous to pclk
`timescale 1ns/100ps

module spe_supply_gate #(
    parameter N = 3
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // request and conditions
    input wire [N-1:0] req,
    input wire [N-1:0] permit,
    // actual state
    output reg [N-1:0] on_ff
);

// ==========================================================
// actual state register
wire [N-1:0] nxt_on = req & permit;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        on_ff <= {N{1'b0}};
    end
    else if (clk_en)
    begin
        on_ff <= nxt_on;
    end
end

endmodule // spe_supply_gate

// ===== spe_supply_regs.v
// supply enable register bank with apb slave and status readback
// assumes apb master on pclk; key and state machine reset come from
// neighbouring power logic, synchronous to pclk
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`include "spe_regs.vh"

module spe_supply_regs #(
    parameter ADDR_W = 8
) (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // power logic
    input wire key_unlocked,
    input wire sm_reset,
    input wire [2:0] supply_permit,
    // enables
    output reg charger_current_enable,
    output reg backup_rail_out_enable,
    output reg aux_converter_enable,
    output reg [3:0] comparator_enable,
    output reg current_limit_switch_enable,
    output reg linear_regulator_4_enable,
    output reg linear_regulator_3_enable,
    // actual supply state
    output wire [2:0] supply_on
);

// ==========================================================
// address decode
function addr_is;
    input [ADDR_W-1:0] a;
    input [7:0] byte_addr;
    begin
        addr_is = (a == byte_addr[ADDR_W-1:0]);
    end
endfunction

// masked merge of write data into a bank
function [15:0] merge_bits;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] mask;
    begin
        merge_bits = (old_val & ~mask) | (new_val & mask);
    end
endfunction

reg [15:0] bank_a_ff;
reg [15:0] bank_b_ff;
reg [15:0] nxt_bank_a;
reg [15:0] nxt_bank_b;
reg [31:0] nxt_prdata;
reg nxt_pslverr;
reg nxt_pready;
wire [2:0] supply_req;
wire [2:0] on_state;
wire hit_a;
wire hit_b;
wire hit_s;
wire hit_any;
wire setup_ph;
wire wr_take;
wire [15:0] wmask_a;

assign hit_a = addr_is(paddr, `SPE_ADDR_BANK_A);
assign hit_b = addr_is(paddr, `SPE_ADDR_BANK_B);
assign hit_s = addr_is(paddr, `SPE_ADDR_STATUS);
assign hit_any = hit_a | hit_b | hit_s;
assign setup_ph = psel & ~penable;
assign wr_take = psel & penable & pwrite & pready;

// ==========================================================
// write masks
// key-guarded charger bit drops out of the mask without the key
assign wmask_a = key_unlocked ? `SPE_A_WMASK
                              : (`SPE_A_WMASK & ~`SPE_A_KEYMASK);

// ==========================================================
// bank next values
always @*
begin
    nxt_bank_a = bank_a_ff;
    nxt_bank_b = bank_b_ff;
    if (sm_reset)
    begin
        nxt_bank_a = `SPE_A_DEFAULT;
        nxt_bank_b = `SPE_B_DEFAULT;
    end
    else if (wr_take && hit_a)
    begin
        // unused and guarded bits keep their value
        nxt_bank_a = merge_bits(bank_a_ff, pwdata[15:0],
                                wmask_a);
    end
    else if (wr_take && hit_b)
    begin
        nxt_bank_b = merge_bits(bank_b_ff, pwdata[15:0],
                                `SPE_B_WMASK);
    end
end

// ==========================================================
// register bank
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        bank_a_ff <= `SPE_A_DEFAULT;
        bank_b_ff <= `SPE_B_DEFAULT;
    end
    else if (clk_en)
    begin
        bank_a_ff <= nxt_bank_a;
        bank_b_ff <= nxt_bank_b;
    end
end

// ==========================================================
// apb answer: ready in the cycle after setup, data latched at setup
always @*
begin
    nxt_pready = setup_ph;
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (setup_ph)
    begin
        nxt_pslverr = ~hit_any;
        if (!pwrite && hit_a)
        begin
            nxt_prdata = {16'h0000, bank_a_ff & `SPE_A_WMASK};
        end
        else if (!pwrite && hit_b)
        begin
            nxt_prdata = {16'h0000, bank_b_ff & `SPE_B_WMASK};
        end
        else if (!pwrite && hit_s)
        begin
            nxt_prdata = {29'h0, on_state};
        end
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
        pready <= nxt_pready;
        prdata <= nxt_prdata;
        pslverr <= nxt_pslverr;
    end
end

// ==========================================================
// enable outputs
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        charger_current_enable <= 1'b1;
        backup_rail_out_enable <= 1'b0;
        aux_converter_enable <= 1'b0;
        comparator_enable <= 4'h0;
        current_limit_switch_enable <= 1'b0;
        linear_regulator_4_enable <= 1'b0;
        linear_regulator_3_enable <= 1'b0;
    end
    else if (clk_en)
    begin
        charger_current_enable <= nxt_bank_a[`SPE_A_CHG_BIT];
        backup_rail_out_enable <= nxt_bank_a[`SPE_A_BACKUP_BIT];
        aux_converter_enable <= nxt_bank_a[`SPE_A_AUX_BIT];
        comparator_enable <=
            nxt_bank_a[`SPE_A_CMP_MSB:`SPE_A_CMP_LSB];
        current_limit_switch_enable <= nxt_bank_b[`SPE_B_LIMSW_BIT];
        linear_regulator_4_enable <= nxt_bank_b[`SPE_B_LREG4_BIT];
        linear_regulator_3_enable <= nxt_bank_b[`SPE_B_LREG3_BIT];
    end
end

// ==========================================================
// actual supply state: request gated by internal conditions
assign supply_req[`SPE_S_LIMSW_BIT] = bank_b_ff[`SPE_B_LIMSW_BIT];
assign supply_req[`SPE_S_LREG4_BIT] = bank_b_ff[`SPE_B_LREG4_BIT];
assign supply_req[`SPE_S_LREG3_BIT] = bank_b_ff[`SPE_B_LREG3_BIT];

spe_supply_gate #(
    .N(3)
) u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .req(supply_req),
    .permit(supply_permit),
    .on_ff(on_state)
);

assign supply_on = on_state;

endmodule // spe_supply_regs

// ===== spe_regs_assertions.sv
// port assertions for the supply enable bank
// assumes spe_supply_regs on one pclk domain
`timescale 1ns/100ps
module spe_chk (
    // clock
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // power logic
    input wire key_unlocked,
    input wire sm_reset,
    input wire [2:0] supply_permit,
    // enables
    input wire charger_current_enable,
    input wire [3:0] comparator_enable,
    input wire current_limit_switch_enable,
    input wire linear_regulator_4_enable,
    input wire linear_regulator_3_enable,
    input wire [2:0] supply_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = clk_en && psel && penable && pwrite && pready;
    wire [2:0] rq = {current_limit_switch_enable,
        linear_regulator_4_enable, linear_regulator_3_enable};
    sequence wr_acc(a);
        wr && paddr == a && !sm_reset;
    endsequence
    sm_def_a: assert property (
        clk_en && sm_reset |=> charger_current_enable && rq == 3'h0)
        else $error("reload missed");
    key_lock_a: assert property (
        !(wr && key_unlocked) && !sm_reset
        |=> $stable(charger_current_enable)) else $error("key ignored");
    chg_write_a: assert property (
        wr_acc(8'h30) ##0 key_unlocked
        |=> charger_current_enable == $past(pwdata[9])) else $error("chg");
    cmp_write_a: assert property (
        wr_acc(8'h30) |=> comparator_enable == $past(pwdata[3:0]))
        else $error("cmp");
    lsw_write_a: assert property (
        wr_acc(8'h34) |=> rq == $past({pwdata[15], pwdata[11:10]}))
        else $error("bank b");
    on_permit_a: assert property (
        clk_en |=> supply_on == $past(rq & supply_permit))
        else $error("supply state");
    err_map_a: assert property (
        pready |-> pslverr == !(paddr inside {8'h30, 8'h34, 8'h3c}))
        else $error("slave error");
    stat_read_a: assert property (
        pready && !pwrite && paddr == 8'h3c
        |-> prdata == {29'h0, $past(supply_on)}) else $error("status");
endmodule // spe_chk
bind spe_supply_regs spe_chk chk_i (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .key_unlocked(key_unlocked),
    .sm_reset(sm_reset),
    .supply_permit(supply_permit),
    .charger_current_enable(charger_current_enable),
    .comparator_enable(comparator_enable),
    .current_limit_switch_enable(current_limit_switch_enable),
    .linear_regulator_4_enable(linear_regulator_4_enable),
    .linear_regulator_3_enable(linear_regulator_3_enable),
    .supply_on(supply_on)
);

// ===== supply_enable_registers_test.sv
// self-checking bench for the supply enable bank
// assumes spe_supply_regs and its checker are compiled
`timescale 1ns/100ps
module supply_enable_registers_test;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg key_unlocked = 0, sm_reset = 0, er, clk_en = 1;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [2:0] supply_permit = 0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [9:0] o;
    wire [2:0] supply_on;
    integer num_errors = 0, n_tests = 0, cyc = 0;
    spe_supply_regs uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_unlocked(key_unlocked),
        .sm_reset(sm_reset), .supply_permit(supply_permit),
        .charger_current_enable(o[9]), .backup_rail_out_enable(o[8]),
        .aux_converter_enable(o[7]), .comparator_enable(o[6:3]),
        .current_limit_switch_enable(o[2]),
        .linear_regulator_4_enable(o[1]),
        .linear_regulator_3_enable(o[0]), .supply_on(supply_on));
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 500)
        begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("mismatch %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    end
    endtask
    task rdchk(input [7:0] a, input [31:0] exp, input e);
    begin
        apb(0, a, 0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    end
    endtask
    task t_key;
    begin
        apb(1, 8'h30, 32'hffffffff);
        rdchk(8'h30, 32'h038f, 0);
        chk({22'h0, o}, 32'h3f8);
        key_unlocked <= 1;
        apb(1, 8'h30, 32'hfffffc70);
        rdchk(8'h30, 0, 0);
        apb(1, 8'h30, 32'h0185);
        chk({22'h0, o}, 32'h1a8);
        key_unlocked <= 0;
        apb(1, 8'h30, 32'h0385);
        rdchk(8'h30, 32'h0185, 0);
    end
    endtask
    task t_freeze;
    begin
        clk_en <= 0;
        sm_reset <= 1;
        supply_permit <= 3'b111;
        repeat (2) @(posedge pclk);
        chk({22'h0, o}, 32'h1af);
        chk({29'h0, supply_on}, 32'h2);
        clk_en <= 1;
        sm_reset <= 0;
        repeat (2) @(posedge pclk);
        chk({22'h0, o}, 32'h1af);
        chk({29'h0, supply_on}, 32'h7);
    end
    endtask
    task t_preset;
    begin
        supply_permit <= 3'b111;
        apb(1, 8'h34, 32'h8c00);
        @(posedge pclk);
        chk({29'h0, supply_on}, 32'h7);
        presetn <= 0;
        @(posedge pclk);
        chk({22'h0, o}, 32'h200);
        chk({29'h0, supply_on}, 32'h0);
        presetn <= 1;
        @(posedge pclk);
        chk({22'h0, o}, 32'h200);
        rdchk(8'h34, 0, 0);
        rdchk(8'h3c, 0, 0);
    end
    endtask
    task t_bank_b;
    begin
        supply_permit <= 3'b101;
        apb(1, 8'h34, 32'hffffffff);
        rdchk(8'h34, 32'h8c00, 0);
        rdchk(8'h3c, 32'h5, 0);
        supply_permit <= 3'b010;
        @(posedge pclk);
        rdchk(8'h3c, 32'h2, 0);
        chk({22'h0, o}, 32'h1af);
    end
    endtask
    task t_smreset;
    begin
        sm_reset <= 1;
        @(posedge pclk);
        sm_reset <= 0;
        @(posedge pclk);
        chk({22'h0, o}, 32'h200);
        rdchk(8'h30, 32'h0200, 0);
        rdchk(8'h3c, 0, 0);
    end
    endtask
    task end_sim;
    begin
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk({22'h0, o}, 32'h200);
        rdchk(8'h34, 0, 0);
        t_key;
        t_bank_b;
        t_freeze;
        rdchk(8'h38, 0, 1);
        apb(1, 8'h38, 32'hffff);
        rdchk(8'h30, 32'h0185, 0);
        t_smreset;
        t_preset;
        end_sim;
    end
endmodule // supply_enable_registers_test
